// >>> cdsp_pkg.sv
// Shared constants and types for the codec datapath and serial port setup bank.
// Assumes one system clock domain; pins are synchronised inside the bank.
package cdsp_pkg;

  // Register indices on the control bus
  localparam logic [7:0] ADDR_PAGE_SEL = 8'h00;
  localparam logic [7:0] ADDR_PLL_FRAC_HIGH = 8'h05;
  localparam logic [7:0] ADDR_PLL_FRAC_LOW = 8'h06;
  localparam logic [7:0] ADDR_DATAPATH = 8'h07;
  localparam logic [7:0] ADDR_SERIAL_A = 8'h08;

  // Values after reset
  localparam logic [7:0] RST_PLL_FRAC_HIGH = 8'h00;
  localparam logic [5:0] RST_PLL_FRAC_LOW = 6'h00;
  localparam logic [7:0] RST_DATAPATH = 8'h00;
  localparam logic [7:0] RST_SERIAL_A = 8'h00;
  localparam logic RST_PAGE = 1'b0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_PLL_FRAC_LOW = 8'hfc;
  localparam logic [7:0] MASK_DATAPATH = 8'hfe;
  localparam logic [7:0] MASK_SERIAL_A = 8'hf4;

  // Field positions
  localparam int unsigned POS_FRAC_LOW = 2;
  localparam int unsigned POS_FSREF = 7;
  localparam int unsigned POS_ADC_DUAL = 6;
  localparam int unsigned POS_DAC_DUAL = 5;
  localparam int unsigned POS_LEFT_ROUTE = 3;
  localparam int unsigned POS_RIGHT_ROUTE = 1;
  localparam int unsigned POS_BCLK_MASTER = 7;
  localparam int unsigned POS_WCLK_MASTER = 6;
  localparam int unsigned POS_DOUT_TRISTATE = 5;
  localparam int unsigned POS_KEEP_CLOCKS = 4;
  localparam int unsigned POS_EFFECT_3D = 2;
  localparam int unsigned POS_PAGE = 0;

  // Bus byte length in bits
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // DAC channel routing codes
  typedef enum logic [1:0] {
    CDSP_ROUTE_MUTE = 2'b00,
    CDSP_ROUTE_SAME = 2'b01,
    CDSP_ROUTE_CROSS = 2'b10,
    CDSP_ROUTE_MONO = 2'b11
  } cdsp_route_t;

  // Control bus slave states
  typedef enum logic [3:0] {
    CDSP_ST_IDLE = 4'b0000,
    CDSP_ST_ADDR = 4'b0001,
    CDSP_ST_ACK_ADDR = 4'b0010,
    CDSP_ST_REG = 4'b0011,
    CDSP_ST_ACK_REG = 4'b0100,
    CDSP_ST_WDATA = 4'b0101,
    CDSP_ST_ACK_W = 4'b0110,
    CDSP_ST_RDATA = 4'b0111,
    CDSP_ST_ACK_R = 4'b1000
  } cdsp_state_t;

  // Decoded settings handed to the datapath
  typedef struct packed {
    logic [13:0] pll_fraction;
    logic fsref_44k1;
    logic adc_dual_rate;
    logic dac_dual_rate;
    cdsp_route_t left_route;
    cdsp_route_t right_route;
    logic bclk_master;
    logic wclk_master;
    logic dout_tristate;
    logic keep_clocks;
    logic effect_3d;
  } cdsp_cfg_t;

endpackage

// >>> cdsp_regs.sv
// Control-bus slave and setup registers for PLL fraction, datapath and serial port A.
// Assumes scl/sda and the bit/word clock pins are asynchronous; everything else is on clk_sys.
//
// Behaviour
// - Fraction low register bits 7..2 hold the six low multiplier bits, reset zero.
// - Fraction low bits 1..0 are read-only zero; software writes zeros there.
// - Datapath bit 7 picks reference rate: 0 is 48 kHz, 1 is 44.1 kHz.
// - Datapath bit 6 enables ADC dual rate, reset off.
// - Datapath bit 5 enables DAC dual rate, reset off.
// - Left routing bits 4..3: mute, left, right, mono mix.
// - Right routing bits 2..1: mute, right, left, mono mix.
// - Serial bit 7: bit clock input when 0, driven output when 1.
// - Serial bit 6: word clock input when 0, driven output when 1.
// - Serial bit 5 set tri-states data output while no valid data goes out.
// - Serial bit 4 decides whether master clocks run during codec power-down.
// - Serial bit 2 enables 3-D effect processing, reset off.
// - High register holds eight top fraction bits, joined with the low register.
// - Register 0 bit 0 selects the page later accesses reach.

`timescale 1ns/1ps
`default_nettype none

module cdsp_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h18,
  parameter int unsigned BCLK_HALF = 4,
  parameter int unsigned WORD_HALF_BITS = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Control bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Serial audio clock pins
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic wclk_i,
  output logic wclk_o,
  output logic wclk_oe,
  // Serial data output pin
  input wire logic dout_bit,
  input wire logic dout_valid,
  output logic dout_o,
  output logic dout_oe,
  // Codec state and settings
  input wire logic codec_power_down,
  output logic bit_edge,
  output var cdsp_pkg::cdsp_cfg_t cfg
);

  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [2:0] bclk_q;
  logic [1:0] wclk_q;
  logic scl_rise, scl_fall, bus_start, bus_stop, wr_stb, rw_r, nack_r, page_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, ptr_r, rd_byte;
  logic [7:0] frac_high_r, frac_low_r, datapath_r, serial_a_r;
  cdsp_pkg::cdsp_state_t state_r;
  logic clk_run;
  logic [$clog2(BCLK_HALF+1)-1:0] div_r;
  logic [$clog2(WORD_HALF_BITS+1)-1:0] wcnt_r;

  // Read view of one register; page 1 is not held here and reads zero except the page select
  function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic pg);
    logic [7:0] val;
    val = 8'h00;
    if (idx == cdsp_pkg::ADDR_PAGE_SEL)
      val = {7'h00, pg};
    else if (!pg)
    begin
      case (idx)
        cdsp_pkg::ADDR_PLL_FRAC_HIGH: val = frac_high_r;
        cdsp_pkg::ADDR_PLL_FRAC_LOW: val = frac_low_r;
        cdsp_pkg::ADDR_DATAPATH: val = datapath_r;
        cdsp_pkg::ADDR_SERIAL_A: val = serial_a_r;
        default: val = 8'h00;
      endcase
    end
    return val;
  endfunction

  // Pin synchronisers; only the second and third stages feed logic
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      bclk_q <= 3'h0;
      wclk_q <= 2'h0;
    end
    else
    begin
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
      bclk_q <= {bclk_q[1:0], bclk_i};
      wclk_q <= {wclk_q[0], wclk_i};
    end
  end

  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign bus_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign bus_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign wr_stb = (state_r == cdsp_pkg::CDSP_ST_WDATA) & scl_fall & (bitcnt_r == cdsp_pkg::BYTE_BITS);
  assign rd_byte = read_reg(ptr_r, page_r);

  // Bus slave: address, index byte, then data bytes with auto-increment
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= cdsp_pkg::CDSP_ST_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      state_r <= cdsp_pkg::CDSP_ST_ADDR;
      bitcnt_r <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_r <= cdsp_pkg::CDSP_ST_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      case (state_r)
        cdsp_pkg::CDSP_ST_ADDR, cdsp_pkg::CDSP_ST_REG, cdsp_pkg::CDSP_ST_WDATA:
        begin
          if (scl_rise && bitcnt_r != cdsp_pkg::BYTE_BITS)
          begin
            shift_r <= {shift_r[6:0], sda_q[1]};
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          else if (scl_fall && bitcnt_r == cdsp_pkg::BYTE_BITS)
          begin
            sda_oe <= 1'b1;
            if (state_r == cdsp_pkg::CDSP_ST_ADDR)
            begin
              rw_r <= shift_r[0];
              if (shift_r[7:1] == DEV_ADDR)
                state_r <= cdsp_pkg::CDSP_ST_ACK_ADDR;
              else
              begin
                state_r <= cdsp_pkg::CDSP_ST_IDLE;
                sda_oe <= 1'b0;
              end
            end
            else if (state_r == cdsp_pkg::CDSP_ST_REG)
            begin
              ptr_r <= shift_r;
              state_r <= cdsp_pkg::CDSP_ST_ACK_REG;
            end
            else
            begin
              ptr_r <= ptr_r + 8'h01;
              state_r <= cdsp_pkg::CDSP_ST_ACK_W;
            end
          end
        end
        cdsp_pkg::CDSP_ST_ACK_ADDR, cdsp_pkg::CDSP_ST_ACK_REG, cdsp_pkg::CDSP_ST_ACK_W:
        begin
          if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (state_r == cdsp_pkg::CDSP_ST_ACK_ADDR && rw_r)
            begin
              shift_r <= rd_byte;
              sda_oe <= ~rd_byte[7];
              state_r <= cdsp_pkg::CDSP_ST_RDATA;
            end
            else
            begin
              sda_oe <= 1'b0;
              state_r <= (state_r == cdsp_pkg::CDSP_ST_ACK_ADDR) ? cdsp_pkg::CDSP_ST_REG
                                                                  : cdsp_pkg::CDSP_ST_WDATA;
            end
          end
        end
        cdsp_pkg::CDSP_ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (bitcnt_r == 4'h7)
            begin
              sda_oe <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              state_r <= cdsp_pkg::CDSP_ST_ACK_R;
            end
            else
            begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe <= ~shift_r[6];
              bitcnt_r <= bitcnt_r + 4'h1;
            end
          end
        end
        cdsp_pkg::CDSP_ST_ACK_R:
        begin
          if (scl_rise)
            nack_r <= sda_q[1];
          else if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (nack_r)
              state_r <= cdsp_pkg::CDSP_ST_IDLE;
            else
            begin
              shift_r <= rd_byte;
              sda_oe <= ~rd_byte[7];
              state_r <= cdsp_pkg::CDSP_ST_RDATA;
            end
          end
        end
        default: state_r <= cdsp_pkg::CDSP_ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pull low
  assign sda_o = 1'b0;

  // Register writes; reserved bits are masked so they always read zero
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      page_r <= cdsp_pkg::RST_PAGE;
      frac_high_r <= cdsp_pkg::RST_PLL_FRAC_HIGH;
      frac_low_r <= {cdsp_pkg::RST_PLL_FRAC_LOW, 2'b00};
      datapath_r <= cdsp_pkg::RST_DATAPATH;
      serial_a_r <= cdsp_pkg::RST_SERIAL_A;
    end
    else if (wr_stb)
    begin
      if (ptr_r == cdsp_pkg::ADDR_PAGE_SEL)
        page_r <= shift_r[cdsp_pkg::POS_PAGE];
      else if (!page_r)
      begin
        case (ptr_r)
          cdsp_pkg::ADDR_PLL_FRAC_HIGH: frac_high_r <= shift_r;
          cdsp_pkg::ADDR_PLL_FRAC_LOW: frac_low_r <= shift_r & cdsp_pkg::MASK_PLL_FRAC_LOW;
          cdsp_pkg::ADDR_DATAPATH: datapath_r <= shift_r & cdsp_pkg::MASK_DATAPATH;
          cdsp_pkg::ADDR_SERIAL_A: serial_a_r <= shift_r & cdsp_pkg::MASK_SERIAL_A;
          default: page_r <= page_r;
        endcase
      end
    end
  end

  // Settings view; fraction high and low pair into one 14-bit value
  always_comb
  begin
    cfg.pll_fraction = {frac_high_r, frac_low_r[7:cdsp_pkg::POS_FRAC_LOW]};
    cfg.fsref_44k1 = datapath_r[cdsp_pkg::POS_FSREF];
    cfg.adc_dual_rate = datapath_r[cdsp_pkg::POS_ADC_DUAL];
    cfg.dac_dual_rate = datapath_r[cdsp_pkg::POS_DAC_DUAL];
    cfg.left_route = cdsp_pkg::cdsp_route_t'(datapath_r[cdsp_pkg::POS_LEFT_ROUTE +: 2]);
    cfg.right_route = cdsp_pkg::cdsp_route_t'(datapath_r[cdsp_pkg::POS_RIGHT_ROUTE +: 2]);
    cfg.bclk_master = serial_a_r[cdsp_pkg::POS_BCLK_MASTER];
    cfg.wclk_master = serial_a_r[cdsp_pkg::POS_WCLK_MASTER];
    cfg.dout_tristate = serial_a_r[cdsp_pkg::POS_DOUT_TRISTATE];
    cfg.keep_clocks = serial_a_r[cdsp_pkg::POS_KEEP_CLOCKS];
    cfg.effect_3d = serial_a_r[cdsp_pkg::POS_EFFECT_3D];
  end

  // Master clocks stop at power-down unless told to keep running
  assign clk_run = (cfg.bclk_master | cfg.wclk_master) & (~codec_power_down | cfg.keep_clocks);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_r <= '0;
      wcnt_r <= '0;
      bclk_o <= 1'b0;
      wclk_o <= 1'b0;
    end
    else if (!clk_run)
    begin
      // Park low so a restart begins on a clean rising edge
      div_r <= '0;
      wcnt_r <= '0;
      bclk_o <= 1'b0;
      wclk_o <= 1'b0;
    end
    else if (div_r == ($bits(div_r))'(BCLK_HALF - 1))
    begin
      div_r <= '0;
      bclk_o <= ~bclk_o;
      if (bclk_o)
      begin
        if (wcnt_r == ($bits(wcnt_r))'(WORD_HALF_BITS - 1))
        begin
          wcnt_r <= '0;
          wclk_o <= ~wclk_o;
        end
        else
          wcnt_r <= wcnt_r + 1'b1;
      end
    end
    else
      div_r <= div_r + 1'b1;
  end

  // Pin directions, data output drive and bit clock edge for the datapath
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bclk_oe <= 1'b0;
      wclk_oe <= 1'b0;
      dout_o <= 1'b0;
      dout_oe <= 1'b1;
      bit_edge <= 1'b0;
    end
    else
    begin
      bclk_oe <= cfg.bclk_master;
      wclk_oe <= cfg.wclk_master;
      dout_o <= dout_bit;
      dout_oe <= ~(cfg.dout_tristate & ~dout_valid);
      bit_edge <= cfg.bclk_master ? (clk_run && div_r == ($bits(div_r))'(BCLK_HALF - 1) && !bclk_o)
                                  : (bclk_q[1] & ~bclk_q[2]);
    end
  end

  a_frac_low_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && !page_r && ptr_r == cdsp_pkg::ADDR_PLL_FRAC_LOW |=> cfg.pll_fraction[5:0] == $past(shift_r[7:2]))
    else $error("fraction low bits not written");
  a_frac_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 frac_low_r[1:0] == 2'b00)
    else $error("reserved fraction bits not zero");
  a_frac_high_pair: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && !page_r && ptr_r == cdsp_pkg::ADDR_PLL_FRAC_HIGH |=> cfg.pll_fraction[13:6] == $past(shift_r))
    else $error("fraction high bits not written");
  a_fsref_dual_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && !page_r && ptr_r == cdsp_pkg::ADDR_DATAPATH
    |=> {cfg.fsref_44k1, cfg.adc_dual_rate, cfg.dac_dual_rate} == $past(shift_r[7:5]))
    else $error("rate bits not written");
  a_route_fields: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && !page_r && ptr_r == cdsp_pkg::ADDR_DATAPATH
    |=> {cfg.left_route, cfg.right_route} == $past(shift_r[4:1]))
    else $error("routing fields not written");
  a_clock_dirs: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ##1 bclk_oe == $past(cfg.bclk_master) && wclk_oe == $past(cfg.wclk_master))
    else $error("clock pin direction wrong");
  a_dout_hiz: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cfg.dout_tristate && !dout_valid |=> !dout_oe)
    else $error("data output driven while idle");
  a_dout_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cfg.dout_tristate |=> dout_oe)
    else $error("data output released while kept driven");
  a_clk_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
    codec_power_down && !cfg.keep_clocks |=> !bclk_o && !wclk_o)
    else $error("master clocks run during power-down");
  a_effect_3d: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && !page_r && ptr_r == cdsp_pkg::ADDR_SERIAL_A |=> cfg.effect_3d == $past(shift_r[2]))
    else $error("effect enable not written");
  a_page_gate: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_stb && page_r && ptr_r != cdsp_pkg::ADDR_PAGE_SEL |=> $stable(cfg))
    else $error("page 1 write reached page 0");

endmodule // cdsp_regs

`default_nettype wire

// >>> cdsp_host_model.sv
// Control bus master model standing in for the host processor.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module cdsp_host_model (
  // Clock
  input wire logic clk_sys,
  // Control bus wire
  output logic scl,
  output logic sda_low,
  input wire logic sda_line,
  // Read byte result
  output logic rd_valid,
  output logic [7:0] rd_data
);
  // Phases well above the slave's 4-cycle minimum
  localparam int unsigned PH = 6;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end

  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic bus_start();
    sda_low = 1'b0;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda_low = 1'b1;
    tick(PH);
    scl = 1'b0;
    tick(PH);
  endtask

  task automatic bus_stop();
    sda_low = 1'b1;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda_low = 1'b0;
    tick(PH);
  endtask

  // Data only moves while the clock is low, so no false start or stop
  task automatic bit_cyc(input logic drive_low, output logic seen);
    sda_low = drive_low;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    seen = sda_line;
    tick(PH);
    scl = 1'b0;
    tick(PH);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(~b[i], s);
    bit_cyc(1'b0, s);
    ack = ~s;
  endtask

  // Single-byte reads end with a not-acknowledge
  task automatic recv_byte();
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cyc(1'b0, s);
      rd_data[i] = s;
    end
    bit_cyc(1'b0, s);
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask
endmodule // cdsp_host_model

`default_nettype wire

// >>> cdsp_regs_tb_top.sv
// Self-checking bench for the setup bank, driven through the control bus model.
// Assumes the word clock divider is shortened through its parameter.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end

module cdsp_regs_tb_top;
  logic clk_sys, arst_n, scl, sda_low, sda_line, rd_valid, sda_o, sda_oe, bclk_i, bclk_o, bclk_oe;
  logic wclk_o, wclk_oe, dout_bit, dout_valid, dout_o, dout_oe, codec_power_down, bit_edge;
  logic [7:0] rd_data;
  cdsp_pkg::cdsp_cfg_t cfg;
  logic [7:0] exp_q[$];
  int tests_run = 0;
  int fail_count = 0;
  int cycles = 0;

  assign sda_line = !(sda_low || (sda_oe && !sda_o));

  cdsp_regs #(.WORD_HALF_BITS(2)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .bclk_i(bclk_i), .bclk_o(bclk_o), .bclk_oe(bclk_oe), .wclk_i(1'b0), .wclk_o(wclk_o), .wclk_oe(wclk_oe),
    .dout_bit(dout_bit), .dout_valid(dout_valid), .dout_o(dout_o), .dout_oe(dout_oe),
    .codec_power_down(codec_power_down), .bit_edge(bit_edge), .cfg(cfg)
  );

  cdsp_host_model u_host (
    .clk_sys(clk_sys), .scl(scl), .sda_low(sda_low), .sda_line(sda_line), .rd_valid(rd_valid), .rd_data(rd_data)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    // A read that never came back still owes its comparison
    if (exp_q.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    logic a;
    u_host.bus_start();
    u_host.send_byte(8'h30, a);
    u_host.send_byte(idx, a);
    u_host.send_byte(val, a);
    u_host.bus_stop();
  endtask

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e);
    logic a;
    exp_q.push_back(e);
    u_host.bus_start();
    u_host.send_byte(8'h30, a);
    u_host.send_byte(idx, a);
    u_host.bus_start();
    u_host.send_byte(8'h31, a);
    u_host.recv_byte();
    u_host.bus_stop();
  endtask

  task automatic count_clk(input int n, output int nb, output int nw, output int ne);
    logic pb, pw;
    nb = 0;
    nw = 0;
    ne = 0;
    repeat (n)
    begin
      pb = bclk_o;
      pw = wclk_o;
      @(posedge clk_sys);
      #1;
      nb += int'(bclk_o && !pb);
      nw += int'(wclk_o && !pw);
      ne += int'(bit_edge === 1'b1);
    end
  endtask

  // Link clock only runs inside a burst, offset from the system clock
  task automatic link_burst(input int n);
    #1.3;
    repeat (n)
    begin
      #40 bclk_i = 1'b1;
      #40 bclk_i = 1'b0;
    end
  endtask

  always @(posedge clk_sys)
  begin
    logic [7:0] e;
    if (rd_valid === 1'b1)
    begin
      e = exp_q.pop_front();
      `CHK("read byte", rd_data, e)
    end
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    int frac, nb, nw, ne;
    logic [7:0] v;
    arst_n = 1'b0;
    bclk_i = 1'b0;
    dout_bit = 1'b0;
    dout_valid = 1'b0;
    codec_power_down = 1'b0;
    void'($urandom(32'hf5be91db));
    repeat (20) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    count_clk(4, nb, nw, ne);
    `CHK("cfg", cfg, '0)
    for (int i = 5; i < 9; i++)
      reg_rd(8'(i), 8'h00);
    $display("test reset done");
    frac = int'($urandom % 32'd10000);
    reg_wr(8'h05, 8'(frac >> 6));
    reg_wr(8'h06, {6'(frac), 2'b00});
    `CHK("fraction", cfg.pll_fraction, 14'(frac))
    reg_rd(8'h06, {6'(frac), 2'b00});
    $display("test fraction done");
    for (int k = 0; k < 4; k++)
    begin
      // Both dual rates equal, reserved bit zero
      v = {1'($urandom), 1'(k), 1'(k), 2'(k), 2'(3 - k), 1'b0};
      reg_wr(8'h07, v);
      `CHK("fsref", cfg.fsref_44k1, v[7])
      `CHK("adc dual", cfg.adc_dual_rate, v[6])
      `CHK("dac dual", cfg.dac_dual_rate, v[5])
      `CHK("left route", cfg.left_route, cdsp_pkg::cdsp_route_t'(v[4:3]))
      `CHK("right route", cfg.right_route, cdsp_pkg::cdsp_route_t'(v[2:1]))
      reg_rd(8'h07, v);
    end
    $display("test datapath done");
    reg_wr(8'h08, 8'hc0);
    count_clk(80, nb, nw, ne);
    `CHK("bit clock out", bclk_oe, 1'b1)
    `CHK("word clock out", wclk_oe, 1'b1)
    `CHK("bit clock runs", nb >= 9, 1'b1)
    `CHK("word clock runs", nw >= 2, 1'b1)
    `CHK("master bit edges", ne, nb)
    codec_power_down = 1'b1;
    count_clk(8, nb, nw, ne);
    count_clk(80, nb, nw, ne);
    `CHK("clocks stop", nb + nw, 0)
    reg_wr(8'h08, 8'hd0);
    count_clk(80, nb, nw, ne);
    `CHK("clocks kept", nb >= 9, 1'b1)
    codec_power_down = 1'b0;
    $display("test clocks done");
    reg_wr(8'h08, 8'h24);
    `CHK("3-D effect", cfg.effect_3d, 1'b1)
    `CHK("bit clock in", bclk_oe, 1'b0)
    `CHK("word clock in", wclk_oe, 1'b0)
    `CHK("data released", dout_oe, 1'b0)
    dout_bit = 1'($urandom);
    dout_valid = 1'b1;
    count_clk(2, nb, nw, ne);
    `CHK("data driven", dout_oe, 1'b1)
    `CHK("data bit", dout_o, dout_bit)
    dout_valid = 1'b0;
    reg_wr(8'h08, 8'hf4);
    reg_rd(8'h08, 8'hf4);
    reg_wr(8'h08, 8'h00);
    count_clk(2, nb, nw, ne);
    `CHK("data held", dout_oe, 1'b1)
    fork
      link_burst(8);
      count_clk(136, nb, nw, ne);
    join
    `CHK("bit edges", ne, 8)
    $display("test serial port done");
    reg_wr(8'h00, 8'h01);
    reg_rd(8'h00, 8'h01);
    reg_wr(8'h07, ~v);
    reg_rd(8'h07, 8'h00);
    reg_wr(8'h00, 8'h00);
    reg_rd(8'h07, v);
    reg_rd(8'h20, 8'h00);
    $display("test page done");
    count_clk(8, nb, nw, ne);
    summarize();
  end
endmodule // cdsp_regs_tb_top

`default_nettype wire
